/* File: qdl_sync.sv */
// ****************************************************************
// Shared constants
// ****************************************************************
package qdl_pkg;
    // Serial word layout
    localparam int WORD_W = 16;
    localparam int NUM_CH = 4;
    localparam int CODE_W = 12;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 14;
    localparam int RANGE_BIT = 13;
    localparam int VAMP_BIT = 12;
    localparam int CODE_HI = 11;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h0F;
    localparam logic [CNT_W-1:0] FULL_WORD = 5'h10;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IN_BASE = 8'h10;
    localparam logic [7:0] OFS_OUT_BASE = 8'h20;

    // Control register fields
    localparam int CTRL_LOAD_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;

    // Status register fields
    localparam int ST_PEND_LO = 0;
    localparam int ST_FRAME_BIT = 4;
    localparam int ST_DRIVE_BIT = 5;
    localparam int ST_CHAIN_BIT = 6;
    localparam int ST_CNT_LO = 8;

    // Channel register fields
    localparam int CH_RANGE_BIT = 13;
    localparam int CH_VAMP_BIT = 12;

    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Link sequencer states
    typedef enum logic [1:0] {
        QDL_IDLE = 2'b00,
        QDL_SHIFT = 2'b01,
        QDL_HOLD = 2'b10
    } qdl_state_t;
endpackage

`timescale 1ns/1ps

// ****************************************************************
// Two-stage synchroniser for pin inputs
// ****************************************************************
module qdl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous inputs and synchronised copies
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

/* File: qdl_top.sv */
// What this block does
// - Serial interface wakes on frame select fall, ignores clock and data after rise.
// - Chain enable high selects daisy-chain mode, low selects standalone mode.
// - In daisy-chain mode every shift clock reaches the shift register while framed.
// - Beyond sixteen pulses in daisy-chain mode oldest bits leave on chain out.
// - Chain out changes on shift clock rise, valid at the next fall.
// - A shared low load strobe updates all channel outputs together.
// - A completed valid word is copied into the addressed input register.
// - With load strobe high output registers hold regardless of input writes.
// - With load strobe low output registers follow the input registers.
// - An output register loads only if its input was written since last load.
// - Code, range double and reference amplifier bit move to outputs together.
// - Synchronous mode updates outputs after the sixteenth falling shift clock edge in standalone mode, after frame select rise in daisy-chain mode.
// - Asynchronous mode updates outputs only when the load strobe goes low.
// - Sleep low powers down, sleep high runs normally.
// - During power-down channel outputs are disconnected and three-state; here dac_drive_en_o goes low while codes stay driven.
// - Power-down keeps registers and still allows serial writes and loads.
// - Outputs show current output registers as soon as sleep returns high.
// - Word bits: two channel address, range double, reference amplifier, code.
// - Standalone mode ignores clocks after the sixteenth fall until a new frame.
// - Frame select rising before sixteen falls aborts and leaves inputs unchanged.
// - Zero-all low clears every input and output register.
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps

module qdl_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial link pins
    input wire logic shift_clock_i,
    input wire logic frame_select_n_i,
    input wire logic serial_in_i,
    output logic chain_out_o,
    // Control pins
    input wire logic chain_enable_i,
    input wire logic load_outputs_n_i,
    input wire logic sleep_n_i,
    input wire logic zero_all_n_i,
    // Channel outputs to the converter
    output logic [qdl_pkg::NUM_CH*qdl_pkg::CODE_W-1:0] dac_code_o,
    output logic [qdl_pkg::NUM_CH-1:0] dac_range_double_o,
    output logic [qdl_pkg::NUM_CH-1:0] dac_vref_amp_o,
    output logic [qdl_pkg::NUM_CH-1:0] dac_drive_en_o
);
    // ************************************************************
    // Pin synchronisation and edge detection
    // ************************************************************
    logic [6:0] pins_async;
    logic [6:0] pins_s;
    logic s_sclk;
    logic s_frame_n;
    logic s_din;
    logic s_chain;
    logic s_load_n;
    logic s_sleep_n;
    logic s_zero_n;
    logic sclk_prev_q;
    logic frame_prev_q;
    logic sclk_fall;
    logic sclk_rise;
    logic frame_fall;

    assign pins_async = {zero_all_n_i, sleep_n_i, load_outputs_n_i, chain_enable_i,
                         serial_in_i, frame_select_n_i, shift_clock_i};

    qdl_sync #(.W(7), .RST_VAL(7'h72)) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(pins_async),
        .sync_o(pins_s)
    );

    // Synchronised pin names
    assign s_sclk = pins_s[0];
    assign s_frame_n = pins_s[1];
    assign s_din = pins_s[2];
    assign s_chain = pins_s[3];
    assign s_load_n = pins_s[4];
    assign s_sleep_n = pins_s[5];
    assign s_zero_n = pins_s[6];

    // Previous levels for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_prev_q <= 1'b0;
            frame_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= s_sclk;
            frame_prev_q <= s_frame_n;
        end
    end

    // Edge strobes
    assign sclk_fall = sclk_prev_q & ~s_sclk;
    assign sclk_rise = ~sclk_prev_q & s_sclk;
    assign frame_fall = frame_prev_q & ~s_frame_n;

    // ************************************************************
    // Serial frame sequencer
    // ************************************************************
    qdl_pkg::qdl_state_t state_q;
    logic [qdl_pkg::CNT_W-1:0] bit_cnt_q;
    logic [qdl_pkg::WORD_W-1:0] shift_q;
    logic commit_q;
    logic commit_d;
    logic framed;
    logic clear_all;
    logic soft_load_q;
    logic soft_clear_q;

    assign framed = (state_q == qdl_pkg::QDL_SHIFT);
    assign clear_all = ~s_zero_n | soft_clear_q;

    // Frame state transitions
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= qdl_pkg::QDL_IDLE;
        end else begin
            case (state_q)
                qdl_pkg::QDL_IDLE: begin
                    if (frame_fall) begin
                        state_q <= qdl_pkg::QDL_SHIFT;
                    end
                end
                qdl_pkg::QDL_SHIFT: begin
                    if (s_frame_n) begin
                        state_q <= qdl_pkg::QDL_IDLE;
                    end else if (sclk_fall && !s_chain && bit_cnt_q == qdl_pkg::LAST_BIT) begin
                        state_q <= qdl_pkg::QDL_HOLD;
                    end
                end
                qdl_pkg::QDL_HOLD: begin
                    if (s_frame_n) begin
                        state_q <= qdl_pkg::QDL_IDLE;
                    end
                end
                default: begin
                    state_q <= qdl_pkg::QDL_IDLE;
                end
            endcase
        end
    end

    // Falling edge counter, saturating at a full word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_cnt_q <= '0;
        end else if (frame_fall) begin
            bit_cnt_q <= '0;
        end else if (framed && sclk_fall && bit_cnt_q != qdl_pkg::FULL_WORD) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // Input shift register, MSB first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_q <= '0;
        end else if (framed && sclk_fall) begin
            shift_q <= {shift_q[qdl_pkg::WORD_W-2:0], s_din};
        end
    end

    // Commit decision: standalone at sixteenth fall, chain at frame close
    always_comb begin
        commit_d = 1'b0;
        if (framed) begin
            if (!s_chain) begin
                commit_d = sclk_fall && !s_frame_n && bit_cnt_q == qdl_pkg::LAST_BIT;
            end else begin
                commit_d = s_frame_n && bit_cnt_q == qdl_pkg::FULL_WORD;
            end
        end
    end

    // One-cycle commit strobe, word then stable in shift_q
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            commit_q <= 1'b0;
        end else begin
            commit_q <= commit_d;
        end
    end

    // ************************************************************
    // Daisy-chain output
    // ************************************************************
    // update on shift clock rise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chain_out_o <= 1'b0;
        end else if (framed && s_chain && sclk_rise) begin
            chain_out_o <= shift_q[qdl_pkg::WORD_W-1];
        end
    end

    // ************************************************************
    // Input, output registers and pending flags
    // ************************************************************
    logic [qdl_pkg::CODE_W-1:0] in_code_q [qdl_pkg::NUM_CH];
    logic [qdl_pkg::NUM_CH-1:0] in_range_q;
    logic [qdl_pkg::NUM_CH-1:0] in_vamp_q;
    logic [qdl_pkg::CODE_W-1:0] out_code_q [qdl_pkg::NUM_CH];
    logic [qdl_pkg::NUM_CH-1:0] pend_q;
    logic [qdl_pkg::NUM_CH-1:0] in_wr;
    logic [qdl_pkg::NUM_CH-1:0] out_ld;
    logic load_active;
    logic [1:0] word_addr;

    assign word_addr = shift_q[qdl_pkg::ADDR_HI:qdl_pkg::ADDR_LO];

    // one level strobe loads every pending channel
    assign load_active = ~s_load_n | soft_load_q;

    for (genvar ch = 0; ch < qdl_pkg::NUM_CH; ch++) begin : g_ch
        assign in_wr[ch] = commit_q && (word_addr == 2'(ch));
        assign out_ld[ch] = load_active && pend_q[ch];
        // Input register
        always_ff @(posedge clk_i) begin
            if (rst_i || clear_all) begin
                in_code_q[ch] <= '0;
                in_range_q[ch] <= 1'b0;
                in_vamp_q[ch] <= 1'b0;
            end else if (in_wr[ch]) begin
                in_code_q[ch] <= shift_q[qdl_pkg::CODE_HI:0];
                in_range_q[ch] <= shift_q[qdl_pkg::RANGE_BIT];
                in_vamp_q[ch] <= shift_q[qdl_pkg::VAMP_BIT];
            end
        end
        // Pending flag, set wins over clear
        always_ff @(posedge clk_i) begin
            if (rst_i || clear_all) begin
                pend_q[ch] <= 1'b0;
            end else if (in_wr[ch]) begin
                pend_q[ch] <= 1'b1;
            end else if (out_ld[ch]) begin
                pend_q[ch] <= 1'b0;
            end
        end
        // Output register, also the channel output port
        always_ff @(posedge clk_i) begin
            if (rst_i || clear_all) begin
                out_code_q[ch] <= '0;
                dac_range_double_o[ch] <= 1'b0;
                dac_vref_amp_o[ch] <= 1'b0;
            end else if (out_ld[ch]) begin
                out_code_q[ch] <= in_code_q[ch];
                dac_range_double_o[ch] <= in_range_q[ch];
                dac_vref_amp_o[ch] <= in_vamp_q[ch];
            end
        end
        // Channel code onto the output bus
        assign dac_code_o[ch*qdl_pkg::CODE_W +: qdl_pkg::CODE_W] = out_code_q[ch];
        // Amplifier connection follows synchronised sleep one clock later
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                dac_drive_en_o[ch] <= 1'b1;
            end else begin
                dac_drive_en_o[ch] <= s_sleep_n;
            end
        end
    end

    // ************************************************************
    // Wishbone register slave
    // ************************************************************
    logic wb_req;
    logic wb_wr_take;
    logic [31:0] rd_d;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr_take = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

    // Acknowledge one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Read data selection
    always_comb begin
        rd_d = qdl_pkg::RST_WORD;
        if (wb_adr_i == qdl_pkg::OFS_STATUS) begin
            rd_d[qdl_pkg::ST_PEND_LO +: qdl_pkg::NUM_CH] = pend_q;
            rd_d[qdl_pkg::ST_FRAME_BIT] = (state_q != qdl_pkg::QDL_IDLE);
            rd_d[qdl_pkg::ST_DRIVE_BIT] = s_sleep_n;
            rd_d[qdl_pkg::ST_CHAIN_BIT] = s_chain;
            rd_d[qdl_pkg::ST_CNT_LO +: qdl_pkg::CNT_W] = bit_cnt_q;
        end
        for (int i = 0; i < qdl_pkg::NUM_CH; i++) begin
            if (wb_adr_i == qdl_pkg::OFS_IN_BASE + 8'(4 * i)) begin
                rd_d[qdl_pkg::CODE_W-1:0] = in_code_q[i];
                rd_d[qdl_pkg::CH_RANGE_BIT] = in_range_q[i];
                rd_d[qdl_pkg::CH_VAMP_BIT] = in_vamp_q[i];
            end
            if (wb_adr_i == qdl_pkg::OFS_OUT_BASE + 8'(4 * i)) begin
                rd_d[qdl_pkg::CODE_W-1:0] = out_code_q[i];
                rd_d[qdl_pkg::CH_RANGE_BIT] = dac_range_double_o[i];
                rd_d[qdl_pkg::CH_VAMP_BIT] = dac_vref_amp_o[i];
            end
        end
    end

    // Read data captured with the acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= qdl_pkg::RST_WORD;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_d;
        end else if (!wb_cyc_i) begin
            wb_dat_o <= qdl_pkg::RST_WORD;
        end
    end

    // Control pulses, written at the acknowledged edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_load_q <= 1'b0;
            soft_clear_q <= 1'b0;
        end else begin
            soft_load_q <= wb_wr_take && wb_sel_i[0] && wb_adr_i == qdl_pkg::OFS_CTRL
                           && wb_dat_i[qdl_pkg::CTRL_LOAD_BIT];
            soft_clear_q <= wb_wr_take && wb_sel_i[0] && wb_adr_i == qdl_pkg::OFS_CTRL
                            && wb_dat_i[qdl_pkg::CTRL_CLEAR_BIT];
        end
    end
endmodule

/* File: qdl_top_properties.sv */
`timescale 1ns/1ps

// ****************************************************************
// Port checker for the serial load block
// ****************************************************************
module qdl_top_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    // Pins
    input wire logic frame_select_n_i,
    input wire logic chain_enable_i,
    input wire logic load_outputs_n_i,
    input wire logic sleep_n_i,
    input wire logic zero_all_n_i,
    input wire logic chain_out_o,
    // Channel outputs
    input wire logic [qdl_pkg::NUM_CH*qdl_pkg::CODE_W-1:0] dac_code_o,
    input wire logic [qdl_pkg::NUM_CH-1:0] dac_drive_en_o
);
    logic [3:0] quiet_q;

    // Cycles since the last bus write, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i || (wb_cyc_i && wb_stb_i && wb_we_i)) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_drive_off: assert property (!sleep_n_i[*5] |-> dac_drive_en_o == 4'h0)
        else $error("outputs still driven in sleep");
    a_drive_back: assert property (sleep_n_i[*5] |-> dac_drive_en_o == 4'hF)
        else $error("outputs not driven after sleep");
    a_zero_clears: assert property (!zero_all_n_i[*5] |-> dac_code_o == '0)
        else $error("codes not cleared");
    a_outputs_hold: assert property ((load_outputs_n_i && zero_all_n_i)[*6] ##0 quiet_q > 4'h6 |-> $stable(dac_code_o))
        else $error("codes moved with load strobe high");
    a_chain_standalone: assert property (!chain_enable_i[*4] |-> $stable(chain_out_o))
        else $error("chain output moved in standalone");
    a_chain_unframed: assert property (frame_select_n_i[*5] |-> $stable(chain_out_o))
        else $error("chain output moved outside frame");
    a_reset_state: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i ##1 rst_i |=> dac_code_o == '0 && dac_drive_en_o == 4'hF)
        else $error("reset state wrong");
endmodule

bind qdl_top qdl_top_chk i_qdl_top_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
    .frame_select_n_i, .chain_enable_i, .load_outputs_n_i, .sleep_n_i, .zero_all_n_i, .chain_out_o,
    .dac_code_o, .dac_drive_en_o);

/* File: qdl_host_model.sv */
`timescale 1ns/1ps

// Serial host driving the link, shift clock of eight system clocks
module qdl_host_model (
    // System clock pacing the link
    input wire logic clk_i,
    // Link pins towards the block
    output logic shift_clock_o,
    output logic frame_select_n_o,
    output logic serial_in_o,
    // Chained data back from the block
    input wire logic chain_out_i
);
    logic [15:0] rx_q;

    // Idle link: clock still, frame closed
    initial begin
        shift_clock_o = 1'b0;
        frame_select_n_o = 1'b1;
        serial_in_o = 1'b0;
        rx_q = 16'h0000;
    end

    // One frame of n bits, optionally as two byte bursts
    task automatic send(input logic [31:0] bits, input int n, input bit split);
        frame_select_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            shift_clock_o <= 1'b1;
            serial_in_o <= bits[i];
            repeat (4) @(posedge clk_i);
            shift_clock_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            rx_q <= {rx_q[14:0], chain_out_i};
            // pause between bytes, frame kept low
            if (split && i == n - 8) begin
                repeat (16) @(posedge clk_i);
            end
        end
        frame_select_n_o <= 1'b1;
        serial_in_o <= ~serial_in_o;
    endtask
endmodule

/* File: tb_qdl_top.sv */
`timescale 1ns/1ps

module tb_qdl_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic shift_clock_i;
    logic frame_select_n_i;
    logic serial_in_i;
    logic chain_out_o;
    logic chain_enable_i = 1'b0;
    logic load_outputs_n_i = 1'b1;
    logic sleep_n_i = 1'b1;
    logic zero_all_n_i = 1'b1;
    logic [qdl_pkg::NUM_CH*qdl_pkg::CODE_W-1:0] dac_code_o;
    logic [qdl_pkg::NUM_CH-1:0] dac_range_double_o;
    logic [qdl_pkg::NUM_CH-1:0] dac_vref_amp_o;
    logic [qdl_pkg::NUM_CH-1:0] dac_drive_en_o;
    logic [31:0] rd;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_cycles = 0;

    qdl_top i_qdl_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .shift_clock_i, .frame_select_n_i, .serial_in_i, .chain_out_o,
        .chain_enable_i, .load_outputs_n_i, .sleep_n_i, .zero_all_n_i, .dac_code_o,
        .dac_range_double_o, .dac_vref_amp_o, .dac_drive_en_o);

    qdl_host_model i_qdl_host_model (.clk_i(clk_i), .shift_clock_o(shift_clock_i),
        .frame_select_n_o(frame_select_n_i),
        .serial_in_o(serial_in_i), .chain_out_i(chain_out_o));

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    // Hang guard
    always @(posedge clk_i) begin
        n_cycles++;
        if (n_cycles == 30000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Classic single bus cycle, waits for acknowledge
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= wd;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] mask,
        input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0);
        chk(what, rd & mask, exp);
    endtask

    task automatic frame(input logic [31:0] bits, input int n, input bit split);
        i_qdl_host_model.send(bits, n, split);
        repeat (8) @(posedge clk_i);
    endtask

    task automatic pins(input logic ld_n, input logic sl_n, input logic zr_n);
        load_outputs_n_i <= ld_n;
        sleep_n_i <= sl_n;
        zero_all_n_i <= zr_n;
        repeat (6) @(posedge clk_i);
    endtask

    task automatic test_end(input string name);
        $display("test %s finished, mismatches so far %0d", name, n_mismatch);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd_chk("status", qdl_pkg::OFS_STATUS, 32'hFFFFFFFF, 32'h00000020);
        for (int ch = 0; ch < 4; ch++) begin
            rd_chk("input reg", qdl_pkg::OFS_IN_BASE + 8'(4 * ch), 32'hFFFFFFFF, 32'h0);
            rd_chk("output reg", qdl_pkg::OFS_OUT_BASE + 8'(4 * ch), 32'hFFFFFFFF, 32'h0);
        end
        rd_chk("unmapped", 8'hF0, 32'hFFFFFFFF, 32'h0);
        test_end("reset");
        // Writes with load strobe high, then one shared load
        frame(32'h6ABC, 16, 1'b1);
        rd_chk("input ch1", 8'h14, 32'hFFFFFFFF, 32'h2ABC);
        rd_chk("output ch1", 8'h24, 32'hFFFFFFFF, 32'h0);
        frame(32'h0F11, 16, 1'b0);
        frame(32'hF321, 16, 1'b0);
        rd_chk("pending", qdl_pkg::OFS_STATUS, 32'hF, 32'hB);
        pins(1'b0, 1'b1, 1'b1);
        pins(1'b1, 1'b1, 1'b1);
        rd_chk("output ch3", 8'h2C, 32'hFFFFFFFF, 32'h3321);
        chk("codes high", {16'h0, dac_code_o[47:32]}, 32'h00003210);
        chk("codes low", dac_code_o[31:0], 32'h00ABCF11);
        chk("range", {28'h0, dac_range_double_o}, 32'hA);
        chk("vref amp", {28'h0, dac_vref_amp_o}, 32'h8);
        rd_chk("pending", qdl_pkg::OFS_STATUS, 32'hF, 32'h0);
        test_end("async load");
        // Short frame, then overrun frame
        frame(32'h8777, 15, 1'b0);
        rd_chk("input ch2", 8'h18, 32'hFFFFFFFF, 32'h0);
        frame(32'h8123F, 20, 1'b0);
        rd_chk("input ch2", 8'h18, 32'hFFFFFFFF, 32'h0123);
        rd_chk("output ch2", 8'h28, 32'hFFFFFFFF, 32'h0);
        test_end("framing");
        // Load strobe held low, in sleep
        pins(1'b0, 1'b0, 1'b1);
        chk("drive", {28'h0, dac_drive_en_o}, 32'h0);
        rd_chk("output ch2", 8'h28, 32'hFFFFFFFF, 32'h0123);
        frame(32'h3456, 16, 1'b0);
        rd_chk("output ch0", 8'h20, 32'hFFFFFFFF, 32'h3456);
        pins(1'b0, 1'b1, 1'b1);
        chk("drive", {28'h0, dac_drive_en_o}, 32'hF);
        chk("code ch0", {20'h0, dac_code_o[11:0]}, 32'h456);
        pins(1'b1, 1'b1, 1'b1);
        test_end("sync and sleep");
        // Daisy chain, two words in one frame
        chain_enable_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        frame(32'h43210456, 32, 1'b0);
        chk("chained out", {16'h0, i_qdl_host_model.rx_q}, 32'h4321);
        rd_chk("input ch0", 8'h10, 32'hFFFFFFFF, 32'h0456);
        rd_chk("input ch1", 8'h14, 32'hFFFFFFFF, 32'h2ABC);
        chain_enable_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        test_end("daisy");
        // Soft load through control, then clear pin
        wb_xfer(1'b1, qdl_pkg::OFS_CTRL, 32'h1);
        repeat (3) @(posedge clk_i);
        rd_chk("output ch0", 8'h20, 32'hFFFFFFFF, 32'h0456);
        pins(1'b1, 1'b1, 1'b0);
        chk("codes", {8'h0, dac_code_o[47:24]}, 32'h0);
        rd_chk("input ch1", 8'h14, 32'hFFFFFFFF, 32'h0);
        pins(1'b1, 1'b1, 1'b1);
        test_end("clear");
        // Soft clear through control after a fresh write
        frame(32'h1555, 16, 1'b0);
        rd_chk("input ch0", 8'h10, 32'hFFFFFFFF, 32'h1555);
        wb_xfer(1'b1, qdl_pkg::OFS_CTRL, 32'h2);
        repeat (3) @(posedge clk_i);
        rd_chk("input ch0", 8'h10, 32'hFFFFFFFF, 32'h0);
        rd_chk("pending", qdl_pkg::OFS_STATUS, 32'hF, 32'h0);
        test_end("soft clear");
        final_report();
    end
endmodule
